// File: rtl/pia_irq_agg.sv
// Interrupt aggregator: DMA and user event status, masks, batching, MSI/legacy.
`timescale 1ns/1ps
// How it works
// R1 - Flagged descriptor completion raises a DMA interrupt.
// R2 - User drives pulses of one clock, or levels.
// R3 - User interrupt lines are active high.
// R4 - User interrupt width set by module parameter.
// R5 - One interrupt per batch between handler calls.
// R6 - Unserviced pending bits never re-trigger an interrupt.
// R7 - Up to 32 host-visible user status bits.
// R8 - Each FPGA's lines OR into one bit.
// R9 - Passthrough: status follows source, no latching.
// R10 - Cleared mask bit stops that source's interrupts.
// R11 - Host clears status, then sets mask bit.
// R12 - Pulses before arming are lost.
// R13 - Host clears held levels inside user design.
// R14 - Request 32 vectors, adapt to granted count.
// R15 - One vector: 0 is DMA, 1 user.
// R16 - Four vectors: engines 0-2, then user.
// R17 - Eight vectors: transfers, idles, link, user.
// R18 - Sixteen vectors: split engines, link, user bits.
// R19 - Thirty-two vectors: single user bits, combined last.
// R20 - User bits 0-20 at codes 0xA upward.
// R21 - Latched user status holds until host clears.
// R22 - User uses pulses when message interrupts active.
module pia_irq_agg
  import pia_pkg::*;
#(
  parameter int NUM_FPGA = 1,
  parameter int IRQ_W    = 1
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_we,
  input  wire logic                      reg_re,
  output logic      [31:0]               reg_rdata_r,
  input  wire logic [XFER_W-1:0]         desc_done,
  input  wire logic [XFER_W-1:0]         desc_irq_opt,
  input  wire logic [NUM_ENG-1:0]        eng_idle,
  input  wire logic                      link_evt,
  input  wire logic [NUM_FPGA*IRQ_W-1:0] user_irq,
  input  wire logic [2:0]                msi_grant,
  output logic      [2:0]                msi_cap_r,
  output logic                           msi_req_r,
  output logic      [4:0]                msi_vec_r,
  output logic                           legacy_irq_r
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [DMA_W-1:0] dma_stat_r;
  logic [DMA_W-1:0] dma_stat_nxt;
  logic [DMA_W-1:0] dma_mask_r;
  logic [DMA_W-1:0] dma_rep_r;
  logic [DMA_W-1:0] dma_rep_nxt;
  logic [USR_W-1:0] usr_stat_r;
  logic [USR_W-1:0] usr_stat_nxt;
  logic [USR_W-1:0] usr_mask_r;
  logic [USR_W-1:0] usr_rep_r;
  logic [USR_W-1:0] usr_rep_nxt;
  logic [USR_W-1:0] usr_src;
  logic [NUM_FPGA-1:0] usr_or;
  logic             pass_r;
  pia_state_t       st_r;
  pia_state_t       st_nxt;
  pia_evt_t         dma_evt;
  pia_evt_t         dma_new;
  logic [USR_W-1:0] usr_new;
  logic [4:0]       code;
  logic             any_new;
  logic             msi_mode;
  logic             wr_dma_stat;
  logic             wr_dma_mask;
  logic             wr_usr_stat;
  logic             wr_usr_mask;
  logic             wr_ctrl;
  logic             wr_ack;
  logic [31:0]      rd_mux;

  // ****************************************************************
  // User interrupt combining
  // ****************************************************************
  // Width of each FPGA's line group is a parameter of this module.
  pia_user_or #(
    .NUM_FPGA (NUM_FPGA),
    .IRQ_W    (IRQ_W)
  ) u_user_or (
    .clk     (clk),
    .sys_rst (sys_rst),
    .irq_in  (user_irq), // see R4
    .or_out  (usr_or)
  );

  // First FPGA lands in bit 0; unused upper bits stay low.
  always_comb begin
    usr_src = '0;
    usr_src[NUM_FPGA-1:0] = usr_or; // see R7 see R8
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // One strobe per writable register (none for OFS_INFO); unmapped writes are dropped.
  assign wr_dma_stat = reg_we && (reg_addr == OFS_DMA_STAT);
  assign wr_dma_mask = reg_we && (reg_addr == OFS_DMA_MASK);
  assign wr_usr_stat = reg_we && (reg_addr == OFS_USR_STAT);
  assign wr_usr_mask = reg_we && (reg_addr == OFS_USR_MASK);
  assign wr_ctrl     = reg_we && (reg_addr == OFS_CTRL);
  assign wr_ack      = reg_we && (reg_addr == OFS_ACK);

  // Read selection; unmapped offsets read as zero.
  assign rd_mux = (reg_addr == OFS_DMA_STAT) ? 32'(dma_stat_r) :
                  (reg_addr == OFS_DMA_MASK) ? 32'(dma_mask_r) :
                  (reg_addr == OFS_USR_STAT) ? usr_stat_r :
                  (reg_addr == OFS_USR_MASK) ? usr_mask_r :
                  (reg_addr == OFS_CTRL)     ? 32'(pass_r) :
                  (reg_addr == OFS_INFO)     ? {25'h000_0000, msi_grant, 1'b0, st_r} :
                  RST_WORD;

  // ****************************************************************
  // Event status
  // ****************************************************************
  // A transfer event only counts when the descriptor asked for one.
  assign dma_evt.xfer = desc_done & desc_irq_opt; // see R1
  assign dma_evt.idle = eng_idle;
  assign dma_evt.link = link_evt;

  // Write-one-to-clear; a new event in the same cycle wins over the clear.
  assign dma_stat_nxt = (dma_stat_r & ~(wr_dma_stat ? reg_wdata[DMA_W-1:0] : '0))
                      | dma_evt;

  // User bits latch only while armed, so pulses before arming are lost.
  // In passthrough the bit simply mirrors the combined source.
  assign usr_stat_nxt = pass_r ? usr_src : // see R9
                        ((usr_stat_r & ~(wr_usr_stat ? reg_wdata : '0))
                        | (usr_src & usr_mask_r)); // see R21 see R12 see R10

  // Status registers and reported-bit trackers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_stat_r <= '0;
      usr_stat_r <= '0;
      dma_rep_r  <= '0;
      usr_rep_r  <= '0;
    end else begin
      dma_stat_r <= dma_stat_nxt;
      usr_stat_r <= usr_stat_nxt;
      dma_rep_r  <= dma_rep_nxt;
      usr_rep_r  <= usr_rep_nxt;
    end
  end

  // Masks and control written by software.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_mask_r <= '0;
      usr_mask_r <= '0;
      pass_r     <= 1'b0;
    end else begin
      if (wr_dma_mask) begin
        dma_mask_r <= reg_wdata[DMA_W-1:0];
      end
      if (wr_usr_mask) begin
        usr_mask_r <= reg_wdata;
      end
      if (wr_ctrl) begin
        pass_r <= reg_wdata[CTRL_PASS_BIT];
      end
    end
  end

  // ****************************************************************
  // Batch sequencer
  // ****************************************************************
  // Only enabled bits not yet reported form a new batch.
  assign dma_new  = dma_stat_r & dma_mask_r & ~dma_rep_r; // see R6
  assign usr_new  = usr_stat_r & usr_mask_r & ~usr_rep_r; // see R10
  assign any_new  = (|dma_new) || (|usr_new);
  assign msi_mode = (msi_grant != GRANT_0);

  // Bits become reported when their batch is sent and stay so until cleared.
  assign dma_rep_nxt = (dma_rep_r | ((st_r == ST_IDLE) ? dma_new : '0))
                     & dma_stat_nxt; // see R6
  assign usr_rep_nxt = (usr_rep_r | ((st_r == ST_IDLE) ? usr_new : '0))
                     & usr_stat_nxt;

  // One message per batch; the handler's acknowledge opens the next one.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (any_new) begin
          st_nxt = ST_SEND; // see R5
        end
      end
      ST_SEND: begin
        st_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (wr_ack) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Vector code for the batch that is about to go out.
  pia_msi_enc u_enc (
    .grant   (msi_grant), // see R14
    .dma_new (dma_new),
    .usr_new (usr_new),
    .code    (code)
  );

  // State and outputs toward the PCIe core.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r         <= ST_IDLE;
      msi_req_r    <= 1'b0;
      msi_vec_r    <= '0;
      legacy_irq_r <= 1'b0;
      msi_cap_r    <= MSI_CAP_32;
    end else begin
      st_r         <= st_nxt;
      msi_req_r    <= (st_nxt == ST_SEND) && msi_mode; // see R15
      legacy_irq_r <= (st_nxt != ST_IDLE) && !msi_mode;
      msi_cap_r    <= MSI_CAP_32; // see R14
      if (st_r == ST_IDLE && any_new) begin
        msi_vec_r <= code; // see R16 see R17 see R18 see R19
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_r <= RST_WORD;
    end else begin
      reg_rdata_r <= reg_re ? rd_mux : RST_WORD;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_dma_set;
    @(posedge clk) disable iff (sys_rst)
    (desc_done[0] && desc_irq_opt[0]) |=> dma_stat_r[0];
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma event not latched"); // see R1

  property p_no_opt;
    @(posedge clk) disable iff (sys_rst)
    (!dma_stat_r[0] && !(desc_done[0] && desc_irq_opt[0])) |=> !dma_stat_r[0];
  endproperty
  a_no_opt: assert property (p_no_opt) else $error("dma bit set without event"); // see R1

  property p_pass;
    @(posedge clk) disable iff (sys_rst)
    pass_r |=> (usr_stat_r == $past(usr_src));
  endproperty
  a_pass: assert property (p_pass) else $error("passthrough status not following"); // see R9

  property p_sticky;
    @(posedge clk) disable iff (sys_rst)
    (usr_stat_r[0] && !pass_r && !(wr_usr_stat && reg_wdata[0])) |=> usr_stat_r[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("user status lost"); // see R21

  property p_unarmed;
    @(posedge clk) disable iff (sys_rst)
    (!usr_mask_r[0] && !pass_r && !usr_stat_r[0]) |=> !usr_stat_r[0];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed user bit latched"); // see R12

  property p_batch;
    @(posedge clk) disable iff (sys_rst)
    msi_req_r |=> (!msi_req_r && st_r == ST_WAIT);
  endproperty
  a_batch: assert property (p_batch) else $error("second message in a batch"); // see R5

  property p_no_retrigger;
    @(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && !any_new) |=> (st_r == ST_IDLE);
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("send without new bit"); // see R6

  property p_masked;
    @(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && dma_mask_r == '0 && usr_mask_r == '0) |=> st_r == ST_IDLE;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source interrupted"); // see R10

  property p_zero_grant;
    @(posedge clk) disable iff (sys_rst)
    msi_req_r |-> $past(msi_grant) != GRANT_0;
  endproperty
  a_zero_grant: assert property (p_zero_grant) else $error("message with no vectors"); // see R15

  property p_cap;
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> msi_cap_r == MSI_CAP_32;
  endproperty
  a_cap: assert property (p_cap) else $error("wrong vector request"); // see R14

  property p_or;
    @(posedge clk) disable iff (sys_rst)
    (|user_irq[IRQ_W-1:0] && usr_mask_r[0] && !pass_r) |=> ##1 usr_stat_r[0];
  endproperty
  a_or: assert property (p_or) else $error("user line not combined"); // see R8

endmodule

// File: rtl/pia_pkg.sv
// Constants, register offsets and types shared by the interrupt aggregator.
package pia_pkg;

  // ****************************************************************
  // Register map (byte offsets) and reset values
  // ****************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_DMA_STAT  = 8'h00;
  localparam logic [7:0]  OFS_DMA_MASK  = 8'h04;
  localparam logic [7:0]  OFS_USR_STAT  = 8'h08;
  localparam logic [7:0]  OFS_USR_MASK  = 8'h0C;
  localparam logic [7:0]  OFS_CTRL      = 8'h10;
  localparam logic [7:0]  OFS_ACK       = 8'h14;
  localparam logic [7:0]  OFS_INFO      = 8'h18;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam int          CTRL_PASS_BIT = 0;

  // ****************************************************************
  // Event layout and vector grants
  // ****************************************************************
  localparam int          NUM_ENG    = 3;
  localparam int          XFER_W     = 6;
  localparam int          DMA_W      = 10;
  localparam int          USR_W      = 32;
  localparam logic [2:0]  GRANT_0    = 3'h0;
  localparam logic [2:0]  GRANT_1    = 3'h1;
  localparam logic [2:0]  GRANT_4    = 3'h2;
  localparam logic [2:0]  GRANT_8    = 3'h3;
  localparam logic [2:0]  GRANT_16   = 3'h4;
  localparam logic [2:0]  GRANT_32   = 3'h5;
  localparam logic [2:0]  MSI_CAP_32 = 3'h5;
  localparam int          HIT_USR16  = 10;
  localparam int          HIT_USR32  = 10;
  localparam int          USR16_CNT  = 5;
  localparam int          USR32_CNT  = 21;

  // One-hot states of the batch sequencer.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } pia_state_t;

  // DMA side events, laid out as in the DMA status register.
  typedef struct packed {
    logic                link;
    logic [NUM_ENG-1:0]  idle;
    logic [XFER_W-1:0]   xfer;
  } pia_evt_t;

endpackage

// File: rtl/pia_user_or.sv
// OR-combines each FPGA's user interrupt lines into one registered bit.
`timescale 1ns/1ps
module pia_user_or
  import pia_pkg::*;
#(
  parameter int NUM_FPGA = 1,
  parameter int IRQ_W    = 1
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [NUM_FPGA*IRQ_W-1:0] irq_in,
  output logic      [NUM_FPGA-1:0]       or_out
);

  logic [NUM_FPGA-1:0] or_nxt;

  // ****************************************************************
  // Combine
  // ****************************************************************
  // Any high line of a group raises that group's bit; inputs are active high.
  always_comb begin
    or_nxt = '0;
    for (int f = 0; f < NUM_FPGA; f++) begin
      or_nxt[f] = |irq_in[f*IRQ_W +: IRQ_W]; // see R8 see R3
    end
  end

  // One register stage keeps the status path short.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      or_out <= '0;
    end else begin
      or_out <= or_nxt;
    end
  end

endmodule

// File: rtl/pia_msi_enc.sv
// Maps newly reported events to an MSI vector code for the granted count.
`timescale 1ns/1ps
module pia_msi_enc
  import pia_pkg::*;
(
  input  wire logic [2:0]       grant,
  input  pia_evt_t              dma_new,
  input  wire logic [USR_W-1:0] usr_new,
  output logic      [4:0]       code
);

  logic [31:0] hits;

  // Returns the index of the lowest set bit, so lower codes win.
  function automatic logic [4:0] lowest_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h1F;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Per-grant hit vectors
  // ****************************************************************
  // Each bit of hits stands for one vector code of the granted layout.
  always_comb begin
    hits = '0;
    case (grant)
      GRANT_1: begin
        hits[0] = |dma_new; // see R15
        hits[1] = |usr_new;
      end
      GRANT_4: begin
        for (int e = 0; e < NUM_ENG; e++) begin
          hits[e] = |dma_new.xfer[2*e +: 2] | dma_new.idle[e]; // see R16
        end
        hits[0] = hits[0] | dma_new.link;
        hits[3] = |usr_new;
      end
      GRANT_8: begin
        for (int e = 0; e < NUM_ENG; e++) begin
          hits[e]     = |dma_new.xfer[2*e +: 2]; // see R17
          hits[3 + e] = dma_new.idle[e];
        end
        hits[6] = dma_new.link;
        hits[7] = |usr_new;
      end
      GRANT_16, GRANT_32: begin
        hits[3:0] = dma_new.xfer[3:0]; // see R18
        hits[6:4] = dma_new.idle;
        hits[8:7] = dma_new.xfer[5:4];
        hits[9]   = dma_new.link;
        if (grant == GRANT_16) begin
          hits[HIT_USR16 +: USR16_CNT] = usr_new[USR16_CNT-1:0];
          hits[15] = |usr_new[USR_W-1:USR16_CNT];
        end else begin
          hits[HIT_USR32 +: USR32_CNT] = usr_new[USR32_CNT-1:0]; // see R19 see R20
          hits[31] = |usr_new[USR_W-1:USR32_CNT];
        end
      end
      default: begin
        hits = '0;
      end
    endcase
  end

  assign code = lowest_set(hits);

endmodule

// File: tb/pia_user_model.sv
// Behavioural model of the user logic that drives the user interrupt lines.
`timescale 1ns/1ps
module pia_user_model
  import pia_pkg::*;
#(
  parameter int NUM_FPGA = 2,
  parameter int IRQ_W    = 2
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [NUM_FPGA-1:0]       pulse_cmd,
  input  wire logic [NUM_FPGA-1:0]       level_cmd,
  output logic      [NUM_FPGA*IRQ_W-1:0] user_irq
);
  // ****
  // Line drive
  // ****
  // A pulse is one clock on the top line of a group, the shortest legal form.
  // A level sits on the bottom line until the host clears it here.
  always_ff @(posedge clk) begin
    user_irq <= '0;
    for (int f = 0; f < NUM_FPGA; f++) begin
      user_irq[f*IRQ_W]         <= ~sys_rst & level_cmd[f];
      user_irq[f*IRQ_W+IRQ_W-1] <= ~sys_rst & pulse_cmd[f];
    end
  end
endmodule

// File: tb/test_pcie_dma_interrupt_aggregator.sv
// Self-checking bench for the interrupt aggregator.
`timescale 1ns/1ps
module test_pcie_dma_interrupt_aggregator
  import pia_pkg::*;
;
  // ****
  // Stimulus and observed signals
  // ****
  localparam int NF = 2;
  localparam int IW = 2;
  logic              clk          = 1'b0;
  logic              sys_rst      = 1'b1;
  logic [ADDR_W-1:0] reg_addr     = '0;
  logic [31:0]       reg_wdata    = '0;
  logic              reg_we       = 1'b0;
  logic              reg_re       = 1'b0;
  logic [31:0]       reg_rdata_r;
  logic [XFER_W-1:0] desc_done    = '0;
  logic [XFER_W-1:0] desc_irq_opt = '0;
  logic [NUM_ENG-1:0] eng_idle    = '0;
  logic              link_evt     = 1'b0;
  logic [NF*IW-1:0]  user_irq;
  logic [NF-1:0]     pulse_cmd    = '0;
  logic [NF-1:0]     level_cmd    = '0;
  logic [2:0]        msi_grant    = GRANT_0;
  logic [2:0]        msi_cap_r;
  logic              msi_req_r;
  logic [4:0]        msi_vec_r;
  logic              legacy_irq_r;
  int                err_total    = 0;
  int                total_checks = 0;
  int                req_cnt      = 0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Counts every message request seen on the core side.
  always @(posedge clk) begin
    if (msi_req_r === 1'b1) begin
      req_cnt++;
    end
  end

  pia_irq_agg #(.NUM_FPGA(NF), .IRQ_W(IW)) u_pia_irq_agg (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_r(reg_rdata_r), .desc_done(desc_done),
    .desc_irq_opt(desc_irq_opt), .eng_idle(eng_idle), .link_evt(link_evt),
    .user_irq(user_irq), .msi_grant(msi_grant), .msi_cap_r(msi_cap_r),
    .msi_req_r(msi_req_r), .msi_vec_r(msi_vec_r), .legacy_irq_r(legacy_irq_r)
  );

  pia_user_model #(.NUM_FPGA(NF), .IRQ_W(IW)) u_pia_user_model (
    .clk(clk), .sys_rst(sys_rst), .pulse_cmd(pulse_cmd), .level_cmd(level_cmd),
    .user_irq(user_irq)
  );

  // ****
  // Tasks
  // ****
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // One-cycle register read; data is taken in the cycle after the strobe.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    check(reg_rdata_r, exp);
  endtask

  // Raises event k: 0-5 transfers, 6-8 idles, 9 link, 10 upward a user group.
  task automatic evt(input int k, input logic opt);
    @(posedge clk);
    if (k < XFER_W) begin
      desc_done    <= XFER_W'(1 << k);
      desc_irq_opt <= opt ? XFER_W'(1 << k) : '0;
    end else if (k < 9) begin
      eng_idle <= NUM_ENG'(1 << (k - 6));
    end else if (k == 9) begin
      link_evt <= 1'b1;
    end else begin
      pulse_cmd <= NF'(1 << (k - 10));
    end
    @(posedge clk);
    desc_done <= '0;
    eng_idle  <= '0;
    link_evt  <= 1'b0;
    pulse_cmd <= '0;
  endtask

  // Waits a bounded time for one request, then checks its vector.
  task automatic wait_req(input logic [4:0] exp);
    int n0;
    n0 = req_cnt;
    for (int i = 0; i < 20 && req_cnt == n0; i++) begin
      @(posedge clk);
      #1;
    end
    if (req_cnt == n0) begin
      check(32'h0000_0000, 32'h0000_0001);
      give_verdict();
    end else begin
      check({27'h0, msi_vec_r}, {27'h0, exp});
    end
  endtask

  // Checks that no request comes within n cycles.
  task automatic no_req(input int n);
    int n0;
    n0 = req_cnt;
    repeat (n) @(posedge clk);
    #1;
    check(32'(req_cnt - n0), 32'h0000_0000);
  endtask

  // Handler end: clear all status, then end the batch.
  task automatic clear_all();
    wr(OFS_DMA_STAT, 32'h0000_03FF);
    wr(OFS_USR_STAT, 32'hFFFF_FFFF);
    wr(OFS_ACK, 32'h0000_0000);
  endtask

  // Vector code expected for event k under grant g.
  function automatic logic [4:0] exp_code(input logic [2:0] g, input int k);
    case (g)
      GRANT_1: return (k < 10) ? 5'h00 : 5'h01;
      GRANT_4: return (k < 6) ? 5'(k / 2) : (k < 9) ? 5'(k - 6) : (k == 9) ? 5'h00 : 5'h03;
      GRANT_8: return (k < 6) ? 5'(k / 2) : (k < 10) ? 5'(k - 3) : 5'h07;
      default: begin
        if (k < 4) return 5'(k);
        if (k < 6) return 5'(k + 3);
        if (k < 9) return 5'(k - 2);
        if (k == 9) return 5'h09;
        if (g == GRANT_16) return (k < 15) ? 5'(k) : 5'h0F;
        return (k < 31) ? 5'(k) : 5'h1F;
      end
    endcase
  endfunction

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check({29'h0, msi_cap_r}, {29'h0, MSI_CAP_32});
    for (int i = 0; i < 6; i++) rdchk(8'(i * 4), RST_WORD);
    rdchk(OFS_INFO, 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0000);
    // A pulse before the host arms the mask is dropped.
    @(posedge clk);
    msi_grant <= GRANT_8;
    evt(10, 1'b1);
    no_req(8);
    rdchk(OFS_USR_STAT, 32'h0000_0000);
    wr(OFS_USR_STAT, 32'hFFFF_FFFF);
    wr(OFS_DMA_MASK, 32'h0000_03FF);
    wr(OFS_USR_MASK, 32'h0000_0003);
    // Every event under every message grant (GRANT_1 to GRANT_32), with its status bit.
    for (int g = 1; g <= 5; g++) begin
      msi_grant <= 3'(g);
      for (int k = 0; k < 12; k++) begin
        evt(k, 1'b1);
        wait_req(exp_code(3'(g), k));
        rdchk(k < 10 ? OFS_DMA_STAT : OFS_USR_STAT, 32'(1 << (k < 10 ? k : k - 10)));
        clear_all();
      end
    end
    // A completion without the option bit is silent.
    msi_grant <= GRANT_8;
    evt(0, 1'b0);
    no_req(8);
    rdchk(OFS_DMA_STAT, 32'h0000_0000);
    // Events during a batch form exactly one later interrupt.
    evt(9, 1'b1);
    wait_req(5'h06);
    evt(6, 1'b1);
    evt(1, 1'b1);
    no_req(6);
    wr(OFS_ACK, 32'h0000_0000);
    wait_req(5'h00);
    wr(OFS_ACK, 32'h0000_0000);
    no_req(20);
    evt(2, 1'b1);
    wait_req(5'h01);
    clear_all();
    // A cleared mask bit blocks its source until set again.
    wr(OFS_USR_MASK, 32'h0000_0001);
    evt(11, 1'b1);
    no_req(8);
    rdchk(OFS_USR_STAT, 32'h0000_0000);
    wr(OFS_USR_MASK, 32'h0000_0003);
    evt(11, 1'b1);
    wait_req(5'h07);
    clear_all();
    // Latched status outlives the pulse until cleared.
    evt(10, 1'b1);
    wait_req(5'h07);
    repeat (6) @(posedge clk);
    rdchk(OFS_USR_STAT, 32'h0000_0001);
    clear_all();
    rdchk(OFS_USR_STAT, 32'h0000_0000);
    // Passthrough in legacy mode follows a held level.
    @(posedge clk);
    msi_grant <= GRANT_0;
    wr(OFS_CTRL, 32'h0000_0001);
    level_cmd <= 2'b01;
    repeat (6) @(posedge clk);
    #1;
    check({31'h0, legacy_irq_r}, 32'h0000_0001);
    rdchk(OFS_USR_STAT, 32'h0000_0001);
    @(posedge clk);
    level_cmd <= 2'b00;
    repeat (4) @(posedge clk);
    rdchk(OFS_USR_STAT, 32'h0000_0000);
    no_req(2);
    wr(OFS_ACK, 32'h0000_0000);
    #1;
    check({31'h0, legacy_irq_r}, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    give_verdict();
  end
endmodule
